// ==== logic/pscl_panel_link.sv ====
`timescale 1ns/1ps
`default_nettype none

module pscl_panel_link
  import pscl_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               panel_shift_clock,
  input  wire logic               panel_command_line,
  input  wire logic               panel_link_clear_n,
  output logic                    panel_response_line,
  input  wire logic [NUM_SW-1:0]  switch_in,
  output logic      [NUM_LED-1:0] led_state,
  output logic      [15:0]        cmd_word,
  output logic                    cmd_strobe,
  output logic                    cmd_error
);

  localparam logic [15:0] RESP_RESET = pscl_resp_build(5'h00, LED_RESET, ACK_RESET);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NUM_SW+2:0] pins_sync;
  logic              s_clk;
  logic              s_cmd;
  logic              s_clr_n;
  logic [4:0]        s_sw;

  pscl_sync #(.W(NUM_SW + 3)) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({switch_in, panel_link_clear_n, panel_command_line, panel_shift_clock}),
    .sync_out (pins_sync)
  );

  assign s_clk   = pins_sync[0];
  assign s_cmd   = pins_sync[1];
  assign s_clr_n = pins_sync[2];
  assign s_sw    = pins_sync[NUM_SW+2:3];

  // ************************************************************
  // Shift engine
  // ************************************************************
  logic        clk_prev;
  logic        rise;
  logic        fall;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;
  logic        ack_prev;
  logic [15:0] next_rx_sh;
  logic [15:0] next_tx_sh;
  logic [4:0]  next_bit_cnt;
  logic        next_resp;
  logic        next_ack_prev;
  logic [4:0]  next_led;
  logic [15:0] next_cmd_word;
  logic        next_strobe;
  logic        next_error;

  assign rise = s_clk & ~clk_prev;
  assign fall = ~s_clk & clk_prev;

  always_comb begin
    next_rx_sh    = rx_sh;
    next_tx_sh    = tx_sh;
    next_bit_cnt  = bit_cnt;
    next_resp     = panel_response_line;
    next_ack_prev = ack_prev;
    next_led      = led_state;
    next_cmd_word = cmd_word;
    next_strobe   = 1'b0;
    next_error    = 1'b0;
    if (!s_clr_n) begin
      // A clear abandons a half-received frame so the retry starts aligned.
      next_bit_cnt = 5'h00;
      next_tx_sh   = pscl_resp_build(s_sw, led_state, ack_prev);
      next_resp    = next_tx_sh[0];
    end else if (rise) begin
      next_rx_sh   = {s_cmd, rx_sh[15:1]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == LAST_BIT) begin
        next_bit_cnt = 5'h00;
        if (pscl_cmd_legal(next_rx_sh)) begin
          next_ack_prev = 1'b1;
          next_cmd_word = next_rx_sh;
          next_strobe   = 1'b1;
          if (next_rx_sh[CMD_OPC_LSB +: 4] == OPC_SET_LED) begin
            next_led = next_rx_sh[CMD_LED_LSB +: 5];
          end
        end else begin
          next_ack_prev = 1'b0;
          next_error    = 1'b1;
        end
      end
    end else if (bit_cnt == 5'h00) begin
      // Between frames the word tracks the switches; it freezes at the first rising edge.
      next_tx_sh = pscl_resp_build(s_sw, led_state, ack_prev);
      next_resp  = next_tx_sh[0];
    end else if (fall) begin
      next_tx_sh = {1'b0, tx_sh[15:1]};
      next_resp  = tx_sh[1];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_prev            <= 1'b0;
      rx_sh               <= 16'h0000;
      tx_sh               <= RESP_RESET;
      bit_cnt             <= 5'h00;
      panel_response_line <= RESP_RESET[0];
      ack_prev            <= ACK_RESET;
      led_state           <= LED_RESET;
      cmd_word            <= 16'h0000;
      cmd_strobe          <= 1'b0;
      cmd_error           <= 1'b0;
    end else begin
      clk_prev            <= s_clk;
      rx_sh               <= next_rx_sh;
      tx_sh               <= next_tx_sh;
      bit_cnt             <= next_bit_cnt;
      panel_response_line <= next_resp;
      ack_prev            <= next_ack_prev;
      led_state           <= next_led;
      cmd_word            <= next_cmd_word;
      cmd_strobe          <= next_strobe;
      cmd_error           <= next_error;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence last_bit_seq;
    rise && s_clr_n && bit_cnt == LAST_BIT;
  endsequence

  sequence shift_seq;
    fall && !rise && s_clr_n && bit_cnt != 5'h00;
  endsequence

  a_frame_end_once: assert property (last_bit_seq |=> (cmd_strobe || cmd_error) ##1 !(cmd_strobe || cmd_error))
    else $error("frame end did not give exactly one verdict pulse");

  a_legal_parity: assert property (cmd_strobe |-> (^cmd_word) == 1'b0 && !cmd_error)
    else $error("accepted command fails even parity");

  a_ack_follows: assert property ((cmd_strobe |-> ack_prev) and (cmd_error |-> !ack_prev))
    else $error("acknowledge flag disagrees with verdict");

  a_led_update: assert property (cmd_strobe && cmd_word[3:0] == OPC_SET_LED |-> led_state == cmd_word[8:4])
    else $error("LED state not taken from command");

  a_fixed_head: assert property (rise && s_clr_n && bit_cnt < 5'h04 |-> panel_response_line == RESP_FIXED[bit_cnt[1:0]])
    else $error("fixed response bit wrong");

  a_resp_odd: assert property (bit_cnt == 5'h00 && $past(bit_cnt) == 5'h00 |-> ^tx_sh == 1'b1)
    else $error("response word parity not odd");

  a_clear_restart: assert property (!s_clr_n |=> bit_cnt == 5'h00)
    else $error("clear did not restart the frame");

  a_bit_step: assert property (rise && s_clr_n && bit_cnt < LAST_BIT |=> bit_cnt == $past(bit_cnt) + 5'h01)
    else $error("bit counter did not advance on shift clock rise");

  a_shift_out: assert property (shift_seq |=> panel_response_line == $past(tx_sh[1]))
    else $error("response line not advanced on falling edge");

endmodule

`default_nettype wire

// ==== logic/pscl_pkg.sv ====
// Summary of operation
// - Switch state goes out and LED settings come in, every bit moving in step with the shift clock from the main logic.
// - The panel decodes every received command and answers every frame, legal or not, with a 16-bit response word.
// - The response holds switch state, LED state, acknowledge or negative acknowledge, and one odd parity bit.
// - The response shifts out while the command shifts in, and its bits 0 to 3 are fixed so they can go before decoding.
`default_nettype none

package pscl_pkg;

  localparam int        FRAME_BITS   = 16;
  localparam int        NUM_SW       = 5;
  localparam int        NUM_LED      = 5;
  localparam logic [4:0] LAST_BIT    = 5'h0F;

  // Response word layout, bit 0 leaves first.
  localparam int        RESP_FIX_LSB = 0;
  localparam int        RESP_SW_LSB  = 4;
  localparam int        RESP_LED_LSB = 9;
  localparam int        RESP_ACK_BIT = 14;
  localparam int        RESP_PAR_BIT = 15;
  localparam logic [3:0] RESP_FIXED  = 4'hA;

  // Command word layout, bit 0 arrives first; bit 15 is the even parity bit.
  localparam int        CMD_OPC_LSB  = 0;
  localparam int        CMD_LED_LSB  = 4;
  localparam logic [3:0] OPC_READ    = 4'h0;
  localparam logic [3:0] OPC_SET_LED = 4'h1;

  localparam logic [4:0] LED_RESET   = 5'h00;
  localparam logic       ACK_RESET   = 1'b1;

  function automatic logic [15:0] pscl_resp_build(input logic [4:0] sw,
                                                  input logic [4:0] led,
                                                  input logic       ack);
    logic [15:0] w;
    w = 16'h0000;
    w[RESP_FIX_LSB +: 4] = RESP_FIXED;
    w[RESP_SW_LSB +: 5]  = sw;
    w[RESP_LED_LSB +: 5] = led;
    w[RESP_ACK_BIT]      = ack;
    w[RESP_PAR_BIT]      = ~(^w[14:0]);
    return w;
  endfunction

  function automatic logic pscl_cmd_legal(input logic [15:0] w);
    logic par_ok;
    par_ok = ~(^w);
    return par_ok && (w[CMD_OPC_LSB +: 4] == OPC_READ || w[CMD_OPC_LSB +: 4] == OPC_SET_LED);
  endfunction

endpackage

`default_nettype wire

// ==== logic/pscl_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pscl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== tb/pscl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pscl_host_model (
  output logic      panel_shift_clock,
  output logic      panel_command_line,
  output logic      panel_link_clear_n,
  input  wire logic panel_response_line
);
  // ********************
  // Main logic side of the link
  // ********************
  localparam int HALF = 200;

  initial begin
    panel_shift_clock  = 1'b0;
    panel_command_line = 1'b0;
    panel_link_clear_n = 1'b1;
  end

  // The response is taken on the rising edge, after the device had half a period to settle it.
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] resp);
    resp = 16'h0000;
    // Calls start on a system clock edge, so every change is non-blocking to avoid a race.
    for (int i = 0; i < nbits; i++) begin
      panel_command_line <= cmd[i];
      #HALF panel_shift_clock <= 1'b1;
      resp[i] = panel_response_line;
      #HALF panel_shift_clock <= 1'b0;
    end
    // A released line must not keep showing the last bit, or a stale bit could pass.
    panel_command_line <= ~cmd[nbits-1];
  endtask

  task automatic clear_link();
    panel_link_clear_n <= 1'b0;
    #HALF panel_link_clear_n <= 1'b1;
    #HALF;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import pscl_pkg::*;
;
  // ********************
  // Harness
  // ********************
  logic        clk_sys, rstn, sclk, cmd_ln, clr_n, resp_ln, cmd_strobe, cmd_error;
  logic [4:0]  switch_in, led_state, cur_led;
  logic [15:0] cmd_word;
  logic        cur_ack;
  int          fail_count, compares, n_ok, n_err;

  pscl_panel_link uut (.clk_sys(clk_sys), .rstn(rstn), .panel_shift_clock(sclk),
    .panel_command_line(cmd_ln), .panel_link_clear_n(clr_n), .panel_response_line(resp_ln),
    .switch_in(switch_in), .led_state(led_state), .cmd_word(cmd_word),
    .cmd_strobe(cmd_strobe), .cmd_error(cmd_error));
  pscl_host_model host (.panel_shift_clock(sclk), .panel_command_line(cmd_ln),
    .panel_link_clear_n(clr_n), .panel_response_line(resp_ln));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (cmd_strobe === 1'b1) n_ok++;
    if (cmd_error === 1'b1) n_err++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [15:0] mk_cmd(input logic [3:0] opc, input logic [4:0] led,
                                         input logic par_good);
    logic [15:0] w;
    w = {1'b0, 6'h00, led, opc};
    w[15] = (^w[14:0]) ^ ~par_good;
    return w;
  endfunction

  // ********************
  // Scenarios
  // ********************
  task automatic frame(input logic [15:0] cmd, input logic good);
    logic [15:0] r, e;
    int          ok0, er0;
    ok0 = n_ok;
    er0 = n_err;
    e = {1'b0, cur_ack, cur_led, switch_in, RESP_FIXED};
    e[15] = ~(^e[14:0]);
    host.xfer(cmd, 16, r);
    repeat (4) @(posedge clk_sys);
    chk(r, e, "response word");
    chk(16'(n_ok - ok0), {15'h0000, good}, "accept pulse");
    chk(16'(n_err - er0), {15'h0000, ~good}, "refuse pulse");
    if (good && cmd[3:0] == OPC_SET_LED) cur_led = cmd[8:4];
    cur_ack = good;
    chk({11'h000, led_state}, {11'h000, cur_led}, "led state");
    if (good) chk(cmd_word, cmd, "command word");
  endtask

  task automatic set_sw(input logic [4:0] v);
    @(posedge clk_sys) switch_in <= v;
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic t_legal();
    set_sw(5'h0B);
    frame(mk_cmd(OPC_SET_LED, 5'h15, 1'b1), 1'b1);
    set_sw(5'h14);
    frame(mk_cmd(OPC_READ, 5'h00, 1'b1), 1'b1);
    frame(mk_cmd(OPC_SET_LED, 5'h0A, 1'b1), 1'b1);
  endtask

  task automatic t_refused();
    frame(mk_cmd(OPC_SET_LED, 5'h1F, 1'b0), 1'b0);
    frame(mk_cmd(4'h7, 5'h11, 1'b1), 1'b0);
    frame(mk_cmd(OPC_READ, 5'h00, 1'b1), 1'b1);
  endtask

  task automatic t_clear();
    logic [15:0] r, e;
    int          ok0, er0;
    ok0 = n_ok;
    er0 = n_err;
    e = {1'b0, cur_ack, cur_led, switch_in, RESP_FIXED};
    host.xfer(mk_cmd(OPC_SET_LED, 5'h1F, 1'b1), 5, r);
    host.clear_link();
    chk({11'h000, r[4:0]}, {11'h000, e[4:0]}, "cut frame head");
    chk(16'(n_ok + n_err - ok0 - er0), 16'h0000, "cut frame verdict");
    chk({11'h000, led_state}, {11'h000, cur_led}, "cut frame led state");
    set_sw(5'h1F);
    frame(mk_cmd(OPC_SET_LED, 5'h1F, 1'b1), 1'b1);
  endtask

  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    switch_in = 5'h00;
    cur_led = LED_RESET;
    cur_ack = ACK_RESET;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({11'h000, led_state}, {11'h000, LED_RESET}, "reset led state");
    chk(cmd_word, 16'h0000, "reset command word");
    t_legal();
    t_refused();
    t_clear();
    report_and_stop();
  end

  // Seven frames and a cut one need about 50 us; the limit leaves ample margin.
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
